// *** verilog/dsef_top.sv ***
// DMA status event flags with register port, list processes and interrupt
//
// Function
// - Watchdog expiry during foreign carrier sets bit 9
// - Receive entering stopped sets bit 8
// - Host-owned receive descriptor sets bit 7, suspends
// - Receive resumes on poll or recognised frame
// - Bit 7 only after reset or a device-owned fetch
// - Frame received: close descriptor, bit 6, keep running
// - Underflow sets bit 5, suspends, marks status bit 1
// - Jabber sets bit 3, aborts, stops, marks bit 14
// - Host-owned transmit descriptor sets bit 2, suspends
// - Transmit resumes on poll or auto polling
// - Transmit entering stopped sets bit 1
// - Frame sent sets bit 0 if control bit 31
// - Reads keep flags; writing one clears flag
// - Bit 16 ORs unmasked normal flags
// - Bit 15 ORs unmasked abnormal flags
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module dsef_top
  import dsef_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rx_watchdog_expired,
  input  wire logic        rx_carrier_active,
  input  wire logic        rx_fetch_done,
  input  wire logic        rx_fetch_owned,
  input  wire logic        rx_frame_seen,
  input  wire logic        rx_frame_complete,
  input  wire logic        tx_fetch_done,
  input  wire logic        tx_fetch_owned,
  input  wire logic        tx_underrun,
  input  wire logic        tx_jabber_expired,
  input  wire logic        tx_frame_complete,
  input  wire logic        tx_desc_control_word_ioc,
  output dsef_proc_t       rx_state,
  output dsef_proc_t       tx_state,
  output logic             rx_desc_close,
  output logic             tx_abort,
  output logic             tx_desc_status_starved,
  output logic             tx_desc_status_babble,
  output logic             irq
);

  // Register port decode
  logic        wr_status;
  logic        wr_clear;
  logic        wr_enable;
  logic        wr_control;
  logic [9:0]  clear_bits;

  // Stored state
  logic [9:0]  events_r;
  logic [9:0]  enable_r;
  logic [6:0]  control_r;
  logic [9:0]  events_nxt;
  logic        nrm_sum_r;
  logic        abn_sum_r;
  logic [31:0] rdata_r;
  logic        irq_r;

  // Command pulses to the list processes
  logic        rx_start_cmd;
  logic        rx_stop_cmd;
  logic        rx_poll_cmd;
  logic        tx_start_cmd;
  logic        tx_stop_cmd;
  logic        tx_poll_cmd;

  // Pulses from the list processes
  logic        rx_halt_evt;
  logic        rx_miss_evt;
  logic        tx_halt_evt;
  logic        tx_miss_evt;

  // Event qualifiers
  logic        rx_run;
  logic        tx_run;
  logic        wdog_evt;
  logic        rx_done_evt;
  logic        starve_evt;
  logic        babble_evt;
  logic        tx_done_evt;
  logic [9:0]  set_bits;

  // Read path
  logic [31:0] rdata_nxt;

  // Word is a 10-bit flag field placed into bits 9:0 of a register word
  function automatic logic [31:0] dsef_widen(input logic [9:0] flags);
    dsef_widen = {22'h000000, flags};
  endfunction

  // Access to a given offset with a given strobe
  function automatic logic dsef_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs,
                                    input logic       stb);
    dsef_hit = stb && (addr == ofs);
  endfunction

  // Flag field of a written word, unused bit positions forced to zero
  function automatic logic [9:0] dsef_field(input logic [31:0] data);
    dsef_field = data[9:0] & DSEF_EVT_MASK;
  endfunction

  // One control bit turned into a single-cycle command
  function automatic logic dsef_cmd(input logic        hit,
                                    input logic [31:0] data,
                                    input int          pos);
    dsef_cmd = hit && data[pos];
  endfunction

  // Any flag that is both set and enabled inside one event group
  function automatic logic dsef_any(input logic [9:0] flags,
                                    input logic [9:0] enables,
                                    input logic [9:0] group);
    dsef_any = |(flags & enables & group);
  endfunction

  // Frame, underflow and jabber events count only while their list process is running
  function automatic logic dsef_running(input dsef_proc_t state);
    dsef_running = (state == DSEF_RUNNING);
  endfunction

  // Status word as software sees it: fixed ones, summaries, flags
  function automatic logic [31:0] dsef_status_word(input logic [9:0] flags,
                                                   input logic       nrm,
                                                   input logic       abn);
    logic [31:0] word;
    word                 = DSEF_STATUS_RST | dsef_widen(flags);
    word[DSEF_B_NRM_SUM] = nrm;
    word[DSEF_B_ABN_SUM] = abn;
    dsef_status_word     = word;
  endfunction

  assign wr_status  = dsef_hit(reg_addr, DSEF_OFS_STATUS, reg_wr);
  assign wr_clear   = dsef_hit(reg_addr, DSEF_OFS_CLEAR, reg_wr);
  assign wr_enable  = dsef_hit(reg_addr, DSEF_OFS_ENABLE, reg_wr);
  assign wr_control = dsef_hit(reg_addr, DSEF_OFS_CONTROL, reg_wr);

  // Either the status word or the clear register takes write-one-to-clear
  assign clear_bits = (wr_status || wr_clear) ? dsef_field(reg_wdata) : DSEF_EVT_RST;

  // Control bits that are commands act for one cycle only
  assign rx_start_cmd = dsef_cmd(wr_control, reg_wdata, DSEF_C_RX_START);
  assign rx_stop_cmd  = dsef_cmd(wr_control, reg_wdata, DSEF_C_RX_STOP);
  assign rx_poll_cmd  = dsef_cmd(wr_control, reg_wdata, DSEF_C_RX_POLL);

  // Transmit commands; auto polling is a level and stays in the register
  assign tx_start_cmd = dsef_cmd(wr_control, reg_wdata, DSEF_C_TX_START);
  assign tx_stop_cmd  = dsef_cmd(wr_control, reg_wdata, DSEF_C_TX_STOP);
  assign tx_poll_cmd  = dsef_cmd(wr_control, reg_wdata, DSEF_C_TX_POLL);

  // Receive list process
  dsef_rx_proc u_rx (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .start_cmd   (rx_start_cmd),
    .stop_cmd    (rx_stop_cmd),
    .poll_cmd    (rx_poll_cmd),
    .fetch_done  (rx_fetch_done),
    .fetch_owned (rx_fetch_owned),
    .frame_seen  (rx_frame_seen),
    .state_r     (rx_state),
    .halt_evt_r  (rx_halt_evt),
    .miss_evt_r  (rx_miss_evt)
  );

  // Transmit list process; auto polling resumes it as well as the poll command
  dsef_tx_proc u_tx (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .start_cmd   (tx_start_cmd),
    .stop_cmd    (tx_stop_cmd),
    .poll_cmd    (tx_poll_cmd),
    .auto_poll   (control_r[DSEF_C_AUTOPOLL]),
    .fetch_done  (tx_fetch_done),
    .fetch_owned (tx_fetch_owned),
    .starved     (tx_underrun),
    .babble      (tx_jabber_expired),
    .state_r     (tx_state),
    .halt_evt_r  (tx_halt_evt),
    .miss_evt_r  (tx_miss_evt)
  );

  // Frame, underflow and jabber events only count while their process is running
  assign rx_run      = dsef_running(rx_state);
  assign tx_run      = dsef_running(tx_state);

  // Receive events; the watchdog reflects the line, whatever the process does
  assign wdog_evt    = rx_watchdog_expired && rx_carrier_active;
  assign rx_done_evt = rx_frame_complete && rx_run;

  // Transmit events; jabber wins over an underflow in the same cycle
  assign starve_evt  = tx_underrun && tx_run && !tx_jabber_expired;
  assign babble_evt  = tx_jabber_expired && tx_run;
  assign tx_done_evt = tx_frame_complete && tx_run && tx_desc_control_word_ioc;

  // Gather hardware set requests into the flag layout
  always_comb begin
    set_bits                   = DSEF_EVT_RST;
    // Receive side
    set_bits[DSEF_B_RX_WDOG]   = wdog_evt;
    set_bits[DSEF_B_RX_HALT]   = rx_halt_evt;
    set_bits[DSEF_B_RX_MISS]   = rx_miss_evt;
    set_bits[DSEF_B_RX_DONE]   = rx_done_evt;
    // Transmit side
    set_bits[DSEF_B_TX_STARVE] = starve_evt;
    set_bits[DSEF_B_TX_BABBLE] = babble_evt;
    set_bits[DSEF_B_TX_MISS]   = tx_miss_evt;
    set_bits[DSEF_B_TX_HALT]   = tx_halt_evt;
    set_bits[DSEF_B_TX_DONE]   = tx_done_evt;
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    events_nxt = events_r & ~clear_bits;
    events_nxt = (events_nxt | set_bits) & DSEF_EVT_MASK;
  end

  // Sticky event flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      events_r <= DSEF_EVT_RST;
    end else begin
      events_r <= events_nxt;
    end
  end

  // Interrupt enables, same layout as the flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable_r <= DSEF_EVT_RST;
    end else if (wr_enable) begin
      enable_r <= dsef_field(reg_wdata);
    end
  end

  // Control word; command bits read back as last written
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      control_r <= DSEF_CTRL_RST;
    end else if (wr_control) begin
      control_r <= reg_wdata[6:0];
    end
  end

  // Normal summary follows the flags one cycle later, like the interrupt line
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nrm_sum_r <= 1'h0;
    end else begin
      nrm_sum_r <= dsef_any(events_r, enable_r, DSEF_NRM_MASK);
    end
  end

  // Abnormal summary; timer, early transmit and bus error flags are not kept here
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      abn_sum_r <= 1'h0;
    end else begin
      abn_sum_r <= dsef_any(events_r, enable_r, DSEF_ABN_MASK);
    end
  end

  // Level interrupt, high while any enabled flag is set
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= dsef_any(events_r, enable_r, DSEF_EVT_MASK);
    end
  end

  // Read multiplexer; the clear register and unmapped offsets read zero
  always_comb begin
    rdata_nxt = DSEF_ZERO_WORD;
    if (reg_rd) begin
      case (reg_addr)
        DSEF_OFS_STATUS: begin
          rdata_nxt = dsef_status_word(events_r, nrm_sum_r, abn_sum_r);
        end
        DSEF_OFS_ENABLE:  rdata_nxt = dsef_widen(enable_r);
        DSEF_OFS_CONTROL: rdata_nxt = {25'h0000000, control_r};
        default:          rdata_nxt = DSEF_ZERO_WORD;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe; reads clear nothing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_r <= DSEF_ZERO_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Receive descriptor close, registered so the output comes from a flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_desc_close <= 1'h0;
    end else begin
      rx_desc_close <= rx_done_evt;
    end
  end

  // Abort of the frame on the wire after a jabber expiry
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_abort <= 1'h0;
    end else begin
      tx_abort <= babble_evt;
    end
  end

  // Underflow mark for the transmit status word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_desc_status_starved <= 1'h0;
    end else begin
      tx_desc_status_starved <= starve_evt;
    end
  end

  // Jabber mark for the transmit status word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_desc_status_babble <= 1'h0;
    end else begin
      tx_desc_status_babble <= babble_evt;
    end
  end

  // Register outputs straight from their flops
  assign reg_rdata = rdata_r;
  assign irq       = irq_r;

endmodule // dsef_top
`default_nettype wire

// *** include/dsef_pkg.sv ***
// Constants and types shared by the DMA status event flag logic
package dsef_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] DSEF_OFS_STATUS  = 8'h28;
  localparam logic [7:0] DSEF_OFS_CLEAR   = 8'h2C;
  localparam logic [7:0] DSEF_OFS_ENABLE  = 8'h38;
  localparam logic [7:0] DSEF_OFS_CONTROL = 8'h3C;

  // Event bit positions in the status word
  localparam int DSEF_B_TX_DONE   = 0;
  localparam int DSEF_B_TX_HALT   = 1;
  localparam int DSEF_B_TX_MISS   = 2;
  localparam int DSEF_B_TX_BABBLE = 3;
  localparam int DSEF_B_TX_STARVE = 5;
  localparam int DSEF_B_RX_DONE   = 6;
  localparam int DSEF_B_RX_MISS   = 7;
  localparam int DSEF_B_RX_HALT   = 8;
  localparam int DSEF_B_RX_WDOG   = 9;
  localparam int DSEF_B_ABN_SUM   = 15;
  localparam int DSEF_B_NRM_SUM   = 16;

  // Control register bit positions
  localparam int DSEF_C_RX_START = 0;
  localparam int DSEF_C_RX_STOP  = 1;
  localparam int DSEF_C_RX_POLL  = 2;
  localparam int DSEF_C_TX_START = 3;
  localparam int DSEF_C_TX_STOP  = 4;
  localparam int DSEF_C_TX_POLL  = 5;
  localparam int DSEF_C_AUTOPOLL = 6;

  // Masks of the event groups and reset values
  localparam logic [9:0]  DSEF_EVT_MASK    = 10'h3EF;
  localparam logic [9:0]  DSEF_NRM_MASK    = 10'h045;
  localparam logic [9:0]  DSEF_ABN_MASK    = 10'h3AA;
  localparam logic [31:0] DSEF_STATUS_RST  = 32'hFC000000;
  localparam logic [31:0] DSEF_ZERO_WORD   = 32'h00000000;
  localparam logic [6:0]  DSEF_CTRL_RST    = 7'h00;
  localparam logic [9:0]  DSEF_EVT_RST     = 10'h000;

  // Descriptor list process states
  typedef enum logic [1:0] {
    DSEF_STOPPED,
    DSEF_RUNNING,
    DSEF_SUSPENDED
  } dsef_proc_t;

endpackage

// *** verilog/dsef_rx_proc.sv ***
// Receive descriptor list process: stop, run, suspend, resume
`timescale 1ns/1ns
`default_nettype none
module dsef_rx_proc
  import dsef_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       start_cmd,
  input  wire logic       stop_cmd,
  input  wire logic       poll_cmd,
  input  wire logic       fetch_done,
  input  wire logic       fetch_owned,
  input  wire logic       frame_seen,
  output dsef_proc_t      state_r,
  output logic            halt_evt_r,
  output logic            miss_evt_r
);

  logic prev_owned_r;

  // Process state; a recognised frame or a poll wakes a suspended list
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= DSEF_STOPPED;
    end else begin
      case (state_r)
        DSEF_STOPPED:   if (start_cmd) state_r <= DSEF_RUNNING;
        DSEF_RUNNING: begin
          if (stop_cmd) state_r <= DSEF_STOPPED;
          else if (fetch_done && !fetch_owned) state_r <= DSEF_SUSPENDED;
        end
        DSEF_SUSPENDED: begin
          if (stop_cmd) state_r <= DSEF_STOPPED;
          else if (poll_cmd || frame_seen) state_r <= DSEF_RUNNING;
        end
        default:        state_r <= DSEF_STOPPED;
      endcase
    end
  end

  // Event pulses; a missing buffer is reported once per run of host-owned fetches
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      halt_evt_r   <= 1'h0;
      miss_evt_r   <= 1'h0;
      prev_owned_r <= 1'h1;
    end else begin
      halt_evt_r <= stop_cmd && (state_r != DSEF_STOPPED);
      miss_evt_r <= (state_r == DSEF_RUNNING) && !stop_cmd && fetch_done && !fetch_owned
                    && prev_owned_r;
      if (fetch_done) prev_owned_r <= fetch_owned;
    end
  end

endmodule // dsef_rx_proc
`default_nettype wire

// *** verilog/dsef_tx_proc.sv ***
// Transmit descriptor list process: stop, run, suspend, resume
`timescale 1ns/1ns
`default_nettype none
module dsef_tx_proc
  import dsef_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       start_cmd,
  input  wire logic       stop_cmd,
  input  wire logic       poll_cmd,
  input  wire logic       auto_poll,
  input  wire logic       fetch_done,
  input  wire logic       fetch_owned,
  input  wire logic       starved,
  input  wire logic       babble,
  output dsef_proc_t      state_r,
  output logic            halt_evt_r,
  output logic            miss_evt_r
);

  logic running;
  logic babble_hit;

  assign running    = (state_r == DSEF_RUNNING);
  assign babble_hit = babble && running;

  // Process state; jabber forces stopped, underflow and no descriptor suspend
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= DSEF_STOPPED;
    end else begin
      case (state_r)
        DSEF_STOPPED:   if (start_cmd) state_r <= DSEF_RUNNING;
        DSEF_RUNNING: begin
          if (stop_cmd || babble) state_r <= DSEF_STOPPED;
          else if (starved) state_r <= DSEF_SUSPENDED;
          else if (fetch_done && !fetch_owned) state_r <= DSEF_SUSPENDED;
        end
        DSEF_SUSPENDED: begin
          if (stop_cmd) state_r <= DSEF_STOPPED;
          else if (poll_cmd || auto_poll) state_r <= DSEF_RUNNING;
        end
        default:        state_r <= DSEF_STOPPED;
      endcase
    end
  end

  // One-cycle event pulses toward the status flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      halt_evt_r <= 1'h0;
      miss_evt_r <= 1'h0;
    end else begin
      halt_evt_r <= (stop_cmd && state_r != DSEF_STOPPED) || babble_hit;
      miss_evt_r <= running && !stop_cmd && !babble && !starved
                    && fetch_done && !fetch_owned;
    end
  end

endmodule // dsef_tx_proc
`default_nettype wire

// *** bench/dsef_chk_sva.sv ***
// Port-level checker for the DMA status event flags
`timescale 1ns/1ns
`default_nettype none
module dsef_chk
  import dsef_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_fetch_done,
  input wire logic        rx_fetch_owned,
  input wire logic        rx_frame_seen,
  input wire logic        rx_frame_complete,
  input wire logic        tx_fetch_done,
  input wire logic        tx_fetch_owned,
  input wire logic        tx_underrun,
  input wire logic        tx_jabber_expired,
  input wire dsef_proc_t  rx_state,
  input wire dsef_proc_t  tx_state,
  input wire logic        rx_desc_close,
  input wire logic        tx_abort,
  input wire logic        tx_desc_status_starved,
  input wire logic        tx_desc_status_babble
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Control writes may carry stop commands, which win over events
  wire logic ctl_wr;
  assign ctl_wr = reg_wr && (reg_addr == DSEF_OFS_CONTROL);

  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == DSEF_ZERO_WORD) else $error("read data outside read slot");
  AST_RX_MISS: assert property (
    rx_state == DSEF_RUNNING && rx_fetch_done && !rx_fetch_owned && !ctl_wr
    |=> rx_state == DSEF_SUSPENDED) else $error("rx did not suspend");
  AST_RX_RESUME: assert property (
    rx_state == DSEF_SUSPENDED && rx_frame_seen && !ctl_wr
    |=> rx_state == DSEF_RUNNING) else $error("rx did not resume on frame");
  AST_RX_CLOSE: assert property (
    rx_state == DSEF_RUNNING && rx_frame_complete |=> rx_desc_close) else $error("no rx close");
  AST_CLOSE_CAUSE: assert property (
    rx_desc_close |-> $past(rx_frame_complete)) else $error("rx close without frame");
  AST_TX_STARVE: assert property (
    tx_state == DSEF_RUNNING && tx_underrun && !tx_jabber_expired && !ctl_wr
    |=> tx_desc_status_starved && tx_state == DSEF_SUSPENDED) else $error("underflow missed");
  AST_TX_BABBLE: assert property (
    tx_state == DSEF_RUNNING && tx_jabber_expired
    |=> tx_abort && tx_desc_status_babble && tx_state == DSEF_STOPPED)
    else $error("jabber missed");
  AST_TX_MISS: assert property (
    tx_state == DSEF_RUNNING && tx_fetch_done && !tx_fetch_owned && !ctl_wr && !tx_underrun
    && !tx_jabber_expired |=> tx_state == DSEF_SUSPENDED) else $error("tx did not suspend");

  // Main scenarios reached
  COV_RX_RESUME: cover property (rx_state == DSEF_SUSPENDED ##1 rx_state == DSEF_RUNNING);
  COV_TX_ABORT: cover property (tx_abort);
  COV_READ: cover property (reg_rd ##1 reg_rdata != DSEF_ZERO_WORD);
endmodule // dsef_chk

bind dsef_top dsef_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_fetch_done(rx_fetch_done),
  .rx_fetch_owned(rx_fetch_owned), .rx_frame_seen(rx_frame_seen),
  .rx_frame_complete(rx_frame_complete), .tx_fetch_done(tx_fetch_done),
  .tx_fetch_owned(tx_fetch_owned), .tx_underrun(tx_underrun),
  .tx_jabber_expired(tx_jabber_expired), .rx_state(rx_state), .tx_state(tx_state),
  .rx_desc_close(rx_desc_close), .tx_abort(tx_abort),
  .tx_desc_status_starved(tx_desc_status_starved),
  .tx_desc_status_babble(tx_desc_status_babble));
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the DMA status event flags
`timescale 1ns/1ns
`default_nettype none
module testbench
  import dsef_pkg::*;
;
  logic        clk_sys   = 1'h0;
  logic        sys_rst   = 1'h1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'h0;
  logic        reg_rd    = 1'h0;
  logic [7:0]  ev        = 8'h00; // Event pulses
  logic [3:0]  lvl       = 4'h0;  // ioc, tx owned, rx owned, carrier
  logic [31:0] reg_rdata;
  dsef_proc_t  rx_state;
  dsef_proc_t  tx_state;
  logic        rx_desc_close, tx_abort, tx_starved, tx_babble, irq;
  logic [9:0]  fl = 10'h000; // Expected flags
  logic [9:0]  en = 10'h000; // Expected enables
  int          bad_count = 0;
  int          comparisons = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  dsef_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_watchdog_expired(ev[0]), .rx_carrier_active(lvl[0]), .rx_fetch_done(ev[1]),
    .rx_fetch_owned(lvl[1]), .rx_frame_seen(ev[2]), .rx_frame_complete(ev[3]),
    .tx_fetch_done(ev[4]), .tx_fetch_owned(lvl[2]), .tx_underrun(ev[5]),
    .tx_jabber_expired(ev[6]), .tx_frame_complete(ev[7]), .tx_desc_control_word_ioc(lvl[3]),
    .rx_state(rx_state), .tx_state(tx_state), .rx_desc_close(rx_desc_close),
    .tx_abort(tx_abort), .tx_desc_status_starved(tx_starved),
    .tx_desc_status_babble(tx_babble), .irq(irq));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
  endtask

  // Read data are looked at just after the edge that follows the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    #1 chk(reg_rdata, exp, m);
  endtask

  // Pulse events with levels, then let flags, summaries and irq settle
  task automatic fire(input logic [7:0] v, input logic [3:0] lv);
    @(posedge clk_sys);
    ev  <= v;
    lvl <= lv;
    @(posedge clk_sys);
    ev  <= 8'h00;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic ctl(input logic [31:0] d);
    wr(DSEF_OFS_CONTROL, d);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [31:0] exp_st();
    logic [31:0] w;
    w = DSEF_STATUS_RST | {22'h000000, fl};
    w[DSEF_B_ABN_SUM] = |(fl & en & DSEF_ABN_MASK);
    w[DSEF_B_NRM_SUM] = |(fl & en & DSEF_NRM_MASK);
    return w;
  endfunction

  task automatic st();
    rd(DSEF_OFS_STATUS, exp_st(), "status");
    chk({31'h0, irq}, {31'h0, |(fl & en)}, "irq");
  endtask

  // Hang guard, far beyond the roughly 150 cycles the tests take
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(DSEF_OFS_STATUS, DSEF_STATUS_RST, "reset status");
    wr(DSEF_OFS_ENABLE, 32'h3EF);
    en = 10'h3EF;
    rd(DSEF_OFS_ENABLE, 32'h3EF, "enable");
    rd(8'h00, DSEF_ZERO_WORD, "unmapped");
    ctl(32'h1);
    fire(8'h01, 4'h0);
    st();
    fire(8'h01, 4'h1);
    fl[9] = 1'h1;
    st();
    fire(8'h08, 4'h1);
    fl[6] = 1'h1;
    st();
    chk({30'h0, rx_state}, {30'h0, DSEF_RUNNING}, "rx after frame");
    fire(8'h02, 4'h1);
    fl[7] = 1'h1;
    st();
    chk({30'h0, rx_state}, {30'h0, DSEF_SUSPENDED}, "rx no desc");
    wr(DSEF_OFS_STATUS, 32'h80);
    fl[7] = 1'h0;
    st();
    st();
    fire(8'h04, 4'h1);
    chk({30'h0, rx_state}, {30'h0, DSEF_RUNNING}, "rx frame resume");
    fire(8'h02, 4'h1);
    st();
    ctl(32'h4);
    chk({30'h0, rx_state}, {30'h0, DSEF_RUNNING}, "rx poll resume");
    fire(8'h02, 4'h3);
    fire(8'h02, 4'h1);
    fl[7] = 1'h1;
    st();
    ctl(32'h2);
    fl[8] = 1'h1;
    st();
    chk({30'h0, rx_state}, {30'h0, DSEF_STOPPED}, "rx stop");
    ctl(32'h8);
    fire(8'h80, 4'h0);
    st();
    fire(8'h80, 4'h8);
    fl[0] = 1'h1;
    st();
    fire(8'h10, 4'h0);
    fl[2] = 1'h1;
    st();
    chk({30'h0, tx_state}, {30'h0, DSEF_SUSPENDED}, "tx no desc");
    ctl(32'h20);
    chk({30'h0, tx_state}, {30'h0, DSEF_RUNNING}, "tx poll resume");
    fire(8'h20, 4'h0);
    fl[5] = 1'h1;
    st();
    chk({30'h0, tx_state}, {30'h0, DSEF_SUSPENDED}, "tx underflow");
    ctl(32'h40);
    chk({30'h0, tx_state}, {30'h0, DSEF_RUNNING}, "tx auto resume");
    fire(8'h40, 4'h0);
    fl[3] = 1'h1;
    fl[1] = 1'h1;
    st();
    chk({30'h0, tx_state}, {30'h0, DSEF_STOPPED}, "tx jabber stop");
    wr(DSEF_OFS_ENABLE, 32'h0);
    en = 10'h000;
    st();
    wr(DSEF_OFS_ENABLE, 32'h45);
    en = 10'h045;
    st();
    wr(DSEF_OFS_STATUS, 32'h0);
    st();
    wr(DSEF_OFS_CLEAR, 32'h3EF);
    fl = 10'h000;
    st();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
